// [hdl/baud_timer_pkg.sv]
// Constants, register map and carrier types of the baud rate timer.
// Assumes a 32-bit APB slave, one clock, and an oscillator tick equal to clk.
// Operation
// RULE1: Internal source counts oscillator divided by 12 or 6.
// RULE2: External source counts falling edges of count pin.
// RULE3: Transmit clock from timer 1 or this timer.
// RULE4: Receive clock select works the same, independently.
// RULE5: Baud generation only while either select is set.
// RULE6: High byte rollover reloads count from reload pair.
// RULE7: Reload pair is one 16-bit value, high upper.
// RULE8: Serial baud equals overflow rate divided by 16.
// RULE9: Normal timer advances once per machine cycle.
// RULE10: Baud mode advances osc or osc/2.
// RULE11: Baud rate is osc over n times (65536-reload).
// RULE12: Counter source in baud mode follows pin edges.
// RULE13: Baud rollover never sets overflow flag.
// RULE14: Trigger falling edge sets external flag, no reload.
// RULE15: Software avoids count bytes during baud generation.
// RULE16: Software avoids writing reload during baud generation.
// RULE17: Software stops timer before accessing counts or reloads.
// RULE18: External flag cleared only by software.
// RULE19: Timer runs only while run bit set; reset stopped.
package baud_timer_pkg;
  localparam logic [11:0] ctrl_addr = 12'h000;
  localparam logic [11:0] mode_addr = 12'h004;
  localparam logic [11:0] count_addr = 12'h008;
  localparam logic [11:0] reload_addr = 12'h00c;
  localparam logic [11:0] status_addr = 12'h010;
  localparam int overflow_bit = 7;
  localparam int external_flag_bit = 6;
  localparam int rx_select_bit = 5;
  localparam int tx_select_bit = 4;
  localparam int external_enable_bit = 3;
  localparam int run_bit = 2;
  localparam int source_bit = 1;
  localparam int capture_bit = 0;
  localparam logic [7:0] ctrl_reset = 8'h00;
  localparam logic [1:0] mode_reset = 2'h0;
  localparam logic [15:0] count_reset = 16'h0000;
  localparam logic [15:0] reload_reset = 16'h0000;
  localparam int timer_div_12 = 12;
  localparam int timer_div_6 = 6;
  localparam int baud_div_12 = 2;
  localparam int baud_div_6 = 1;
  localparam int serial_div = 16;
  localparam logic [3:0] serial_div_last = 4'(serial_div - 1);
  typedef struct packed {
    logic tx_clock;
    logic rx_clock;
  } baud_out_type;
endpackage

// [hdl/tick_divider.sv]
// Programmable tick divider: one pulse every div cycles while enabled.
// Assumes div stays between 1 and 2**width.
`timescale 1ns/10ps
module tick_divider #(
  parameter int width = 4
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic enable,
  input wire logic [width-1:0] div_last,
  output logic tick
);
  logic [width-1:0] cnt_ff;
  logic [width-1:0] nxt_cnt;

  // A counter without bits cannot hold a divide ratio, so elaboration stops.
  if (width < 1) begin : g_width_check
    $error("tick_divider width must be at least 1.");
  end

  always_comb begin
    nxt_cnt = cnt_ff;
    if (!enable) begin
      nxt_cnt = '0;
    end else if (cnt_ff >= div_last) begin
      nxt_cnt = '0;
    end else begin
      nxt_cnt = cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign tick = enable && (cnt_ff >= div_last);
endmodule

// [hdl/baud_timer.sv]
// Reloadable 16-bit timer/counter with baud generator mode and APB registers.
// Assumes pins are synchronous to clk and clk is the oscillator.
`timescale 1ns/10ps
module baud_timer (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic six_clock_mode,
  input wire logic count_input_pin,
  input wire logic trigger_input,
  input wire logic timer1_overflow,
  output baud_timer_pkg::baud_out_type baud_out,
  output logic overflow_flag,
  output logic external_flag
);
  import baud_timer_pkg::*;

  logic [7:0] ctrl_ff;
  logic [1:0] mode_ff;
  logic [15:0] count_ff;
  logic [15:0] reload_ff;
  logic pin_ff;
  logic trig_ff;
  logic [3:0] tx_div_ff;
  logic [3:0] rx_div_ff;
  baud_out_type baud_ff;
  logic timer2_ovf_ff;
  logic wr;
  logic rd;
  logic mapped;
  logic run;
  logic baud_mode;
  logic ext_source;
  logic pin_fall;
  logic trig_fall;
  logic tick_internal;
  logic advance;
  logic rollover;
  logic reload_now;
  logic [3:0] div_last;
  logic [15:0] count_next;

  assign wr = psel && penable && pwrite;
  assign rd = psel && !pwrite;
  assign mapped = (paddr == ctrl_addr) || (paddr == mode_addr) ||
    (paddr == count_addr) || (paddr == reload_addr) || (paddr == status_addr);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  assign run = ctrl_ff[run_bit]; // RULE19
  assign baud_mode = ctrl_ff[rx_select_bit] || ctrl_ff[tx_select_bit]; // RULE5
  assign ext_source = ctrl_ff[source_bit];
  assign pin_fall = pin_ff && !count_input_pin;
  assign trig_fall = trig_ff && !trigger_input;

  // Dividers are cycles minus one; baud mode is faster than a machine cycle.
  always_comb begin
    if (baud_mode) begin
      div_last = six_clock_mode ? 4'(baud_div_6 - 1) : 4'(baud_div_12 - 1); // RULE10
    end else begin
      div_last = six_clock_mode ? 4'(timer_div_6 - 1) : 4'(timer_div_12 - 1); // RULE1 RULE9
    end
  end

  tick_divider #(
    .width(4)
  ) u_prescale (
    .clk(clk),
    .rstn(rstn),
    .enable(run && !ext_source),
    .div_last(div_last),
    .tick(tick_internal)
  );

  // The pin is sampled on clk, so edges faster than half the clock are lost.
  assign advance = run && (ext_source ? pin_fall : tick_internal); // RULE2 RULE12
  assign rollover = advance && (count_ff == 16'hffff);
  // Outside baud mode a trigger edge also reloads, when enabled and not capturing.
  assign reload_now = rollover || (!baud_mode && !ctrl_ff[capture_bit] &&
    ctrl_ff[external_enable_bit] && trig_fall); // RULE14
  assign count_next = reload_now ? reload_ff : (count_ff + 16'h0001); // RULE6 RULE7

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_ff <= 1'b1;
      trig_ff <= 1'b1;
    end else begin
      pin_ff <= count_input_pin;
      trig_ff <= trigger_input;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count_ff <= count_reset;
    end else if (wr && paddr == count_addr) begin
      count_ff <= pwdata[15:0];
    end else if (advance || reload_now) begin
      count_ff <= count_next;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reload_ff <= reload_reset;
    end else if (wr && paddr == reload_addr) begin
      reload_ff <= pwdata[15:0];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mode_ff <= mode_reset;
    end else if (wr && paddr == mode_addr) begin
      mode_ff <= pwdata[1:0];
    end
  end

  // Flags: hardware set wins over a software clear in the same cycle.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_ff <= ctrl_reset;
    end else begin
      if (wr && paddr == ctrl_addr) begin
        ctrl_ff <= pwdata[7:0];
      end
      if (rollover && !baud_mode) begin
        ctrl_ff[overflow_bit] <= 1'b1; // RULE13
      end
      if (ctrl_ff[external_enable_bit] && trig_fall) begin
        ctrl_ff[external_flag_bit] <= 1'b1; // RULE14 RULE18
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      timer2_ovf_ff <= 1'b0;
    end else begin
      timer2_ovf_ff <= rollover && baud_mode;
    end
  end

  // Each direction divides its chosen overflow stream by 16 and pulses its clock high for one cycle.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_div_ff <= 4'h0;
      rx_div_ff <= 4'h0;
      baud_ff <= '0;
    end else begin
      if (ctrl_ff[tx_select_bit] ? timer2_ovf_ff : timer1_overflow) begin // RULE3
        tx_div_ff <= tx_div_ff + 4'h1;
        if (tx_div_ff == serial_div_last) begin
          baud_ff.tx_clock <= 1'b1; // RULE8 RULE11
        end else begin
          baud_ff.tx_clock <= 1'b0;
        end
      end else begin
        baud_ff.tx_clock <= 1'b0;
      end
      if (ctrl_ff[rx_select_bit] ? timer2_ovf_ff : timer1_overflow) begin // RULE4
        rx_div_ff <= rx_div_ff + 4'h1;
        if (rx_div_ff == serial_div_last) begin
          baud_ff.rx_clock <= 1'b1; // RULE8
        end else begin
          baud_ff.rx_clock <= 1'b0;
        end
      end else begin
        baud_ff.rx_clock <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prdata <= 32'h0000_0000;
    end else if (rd && !penable) begin
      case (paddr)
        ctrl_addr: prdata <= {24'h000000, ctrl_ff};
        mode_addr: prdata <= {30'h00000000, mode_ff};
        count_addr: prdata <= {16'h0000, count_ff};
        reload_addr: prdata <= {16'h0000, reload_ff};
        status_addr: prdata <= {29'h00000000, baud_mode, run, timer2_ovf_ff};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  assign baud_out = baud_ff;
  assign overflow_flag = ctrl_ff[overflow_bit];
  assign external_flag = ctrl_ff[external_flag_bit];
endmodule

// [tb/baud_timer_monitor.sv]
// Port checker of the baud timer.
// Assumes it is bound onto baud_timer and clk is the only clock.
`timescale 1ns/10ps
module baud_timer_monitor (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic trigger_input,
  input wire baud_timer_pkg::baud_out_type baud_out,
  input wire logic overflow_flag,
  input wire logic external_flag
);
  import baud_timer_pkg::*;
  logic [7:0] ctrl_ff;
  logic wr_ctrl;
  logic mapped;
  logic baud;
  assign wr_ctrl = psel && penable && pwrite && paddr == ctrl_addr;
  assign mapped = paddr <= status_addr && paddr[1:0] == 2'h0;
  assign baud = ctrl_ff[tx_select_bit] || ctrl_ff[rx_select_bit];
  // A shadow of the control word avoids probing the design's internals.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_ff <= ctrl_reset;
    end else if (wr_ctrl) begin
      ctrl_ff <= pwdata[7:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence trig_fall;
    $fell(trigger_input) ##0 baud && ctrl_ff[external_enable_bit];
  endsequence
  chk_ready_high: assert property (pready) else $error("pready low");
  chk_bad_addr: assert property (psel && penable && !mapped |-> pslverr)
    else $error("no slverr");
  chk_good_addr: assert property (psel && penable && mapped |-> !pslverr)
    else $error("false slverr");
  chk_ext_flag_held: assert property (external_flag && !wr_ctrl |=> external_flag)
    else $error("flag lost");
  chk_baud_no_ovf: assert property (baud && !overflow_flag && !wr_ctrl |=> !overflow_flag)
    else $error("overflow set");
  chk_trig_sets_flag: assert property (trig_fall |-> ##[1:6] external_flag)
    else $error("flag not set");
  chk_tx_spacing: assert property (baud_out.tx_clock |=> !baud_out.tx_clock [*8])
    else $error("tx too fast");
  chk_rx_spacing: assert property (baud_out.rx_clock |=> !baud_out.rx_clock [*8])
    else $error("rx too fast");
endmodule
bind baud_timer baud_timer_monitor mon (.clk(clk), .rstn(rstn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .trigger_input(trigger_input), .baud_out(baud_out),
  .overflow_flag(overflow_flag), .external_flag(external_flag));

// [tb/serial_port_model.sv]
// Serial port stand-in: measures the spacing of baud clock pulses.
// Assumes each pulse lasts one clk cycle.
`timescale 1ns/10ps
module serial_port_model (
  input wire logic clk,
  input wire baud_timer_pkg::baud_out_type baud_out,
  output logic [15:0] tx_period,
  output logic [15:0] rx_period
);
  import baud_timer_pkg::*;
  logic [15:0] tx_cnt_ff = 16'h0000;
  logic [15:0] rx_cnt_ff = 16'h0000;
  always @(posedge clk) begin
    tx_cnt_ff <= baud_out.tx_clock ? 16'h0001 : tx_cnt_ff + 16'h0001;
    rx_cnt_ff <= baud_out.rx_clock ? 16'h0001 : rx_cnt_ff + 16'h0001;
    tx_period <= baud_out.tx_clock ? tx_cnt_ff : tx_period;
    rx_period <= baud_out.rx_clock ? rx_cnt_ff : rx_period;
  end
endmodule

// [tb/baud_timer_tb.sv]
// Self-checking bench of the baud timer with a serial port stand-in.
// Assumes package, design and checker are compiled first.
`timescale 1ns/10ps
module baud_timer_tb;
  import baud_timer_pkg::*;
  logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, slv;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, six = 0, pin = 1, trig = 1, t1 = 0, pin_on = 0, t1_on = 0;
  logic ovf, ext;
  baud_out_type bo;
  logic [15:0] txp, rxp, r;
  int error_cnt = 0, checks_done = 0, cyc = 0, e;
  always #5 clk = ~clk;
  baud_timer uut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .six_clock_mode(six), .count_input_pin(pin), .trigger_input(trig),
    .timer1_overflow(t1), .baud_out(bo), .overflow_flag(ovf), .external_flag(ext));
  serial_port_model sp (.clk(clk), .baud_out(bo), .tx_period(txp), .rx_period(rxp));
  // Pin falls every 4 cycles; the other timer overflows every 5.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    pin <= !(pin_on && cyc[1]);
    t1 <= t1_on && cyc % 5 == 0;
  end
  function int period(logic s, logic [15:0] rl);
    return (s ? 16 : 32) * (65536 - rl);
  endfunction
  task tally_and_finish;
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    slv = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
  // The timer is stopped before its counts are touched.
  task baud_run(input logic [31:0] c, input logic [15:0] rl);
    apb(1, ctrl_addr, 0);
    apb(1, reload_addr, {16'h0, rl});
    apb(1, count_addr, {16'h0, rl});
    apb(1, ctrl_addr, c);
    repeat (3) @(posedge bo.rx_clock);
    repeat (3) @(posedge bo.tx_clock);
  endtask
  initial begin
    #900000;
    error_cnt++;
    tally_and_finish;
  end
  initial begin
    void'($urandom(49188));
    repeat (20) @(posedge clk);
    rstn <= 1;
    @(posedge clk);
    apb(0, ctrl_addr, 0);
    chk(rd, ctrl_reset);
    apb(0, 12'h014, 0);
    chk({rd[30:0], slv}, 1);
    for (int i = 0; i < 4; i++) begin
      six <= i[0];
      r = i < 2 ? 16'hffff : 16'hfff0 | 16'($urandom % 16);
      baud_run(32'h34, r);
      chk(txp, period(i[0], r));
      chk(rxp, period(i[0], r));
      chk(ovf, 0);
    end
    baud_run(32'h3c, 16'hfffc);
    trig <= 0;
    repeat (4) @(posedge clk);
    trig <= 1;
    repeat (3) @(posedge bo.tx_clock);
    chk(ext, 1);
    apb(1, ctrl_addr, 32'h3c);
    chk(ext, 0);
    pin_on <= 1;
    baud_run(32'h36, 16'hfffe);
    chk(txp, 128);
    t1_on <= 1;
    baud_run(32'h24, 16'hfff8);
    chk(txp, 80);
    chk(rxp, period(1, 16'hfff8));
    // Plain timer runs for 123 clock cycles in both clock modes.
    for (int m = 0; m < 2; m++) begin
      six <= m[0];
      e = 123 / (m[0] ? 6 : 12);
      apb(1, ctrl_addr, 0);
      apb(1, count_addr, 0);
      apb(1, ctrl_addr, 32'h04);
      repeat (120) @(posedge clk);
      apb(1, ctrl_addr, 0);
      apb(0, count_addr, 0);
      r = rd[15:0];
      chk(r inside {[e - 1:e + 1]}, 1);
      apb(0, count_addr, 0);
      chk(rd[15:0], r);
    end
    tally_and_finish;
  end
endmodule
